// ### core/scr_pkg.sv
// Purpose: constants and types shared by the serial command frame receiver
// Assumes: 100 MHz reference clock, 16x oversampling of the serial line
// Notes:   a command word is {has_arg, command[23:0], argument[23:0]}
package scr_pkg;

	// ------------------------------------------------------------------
	// clock and line timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ    = 100_000_000;
	localparam int unsigned CLK_NS    = 10;
	localparam int unsigned OVS       = 16;
	localparam int unsigned BAUD_1200 = 1200;
	localparam int unsigned BAUD_2400 = 2400;
	localparam int unsigned BAUD_4800 = 4800;
	localparam int unsigned BAUD_9600 = 9600;
	localparam int unsigned BAUD_19200 = 19200;
	// clock cycles per oversampling tick, rounded down
	localparam int unsigned DIV_1200  = CLK_HZ / (BAUD_1200 * OVS);
	localparam int unsigned DIV_2400  = CLK_HZ / (BAUD_2400 * OVS);
	localparam int unsigned DIV_4800  = CLK_HZ / (BAUD_4800 * OVS);
	localparam int unsigned DIV_9600  = CLK_HZ / (BAUD_9600 * OVS);
	localparam int unsigned DIV_19200 = CLK_HZ / (BAUD_19200 * OVS);
	localparam int unsigned DIVW      = 13;
	localparam logic [3:0]  OVS_MID   = 4'h7;
	localparam logic [3:0]  OVS_LAST  = 4'hF;
	localparam logic [2:0]  LAST_BIT  = 3'h7;

	// ------------------------------------------------------------------
	// rate select codes
	// ------------------------------------------------------------------
	localparam logic [2:0] SEL_4800  = 3'h0;
	localparam logic [2:0] SEL_1200  = 3'h1;
	localparam logic [2:0] SEL_2400  = 3'h2;
	localparam logic [2:0] SEL_9600  = 3'h3;
	localparam logic [2:0] SEL_19200 = 3'h4;

	// ------------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------------
	localparam logic [7:0] STX_BYTE   = 8'h02;
	localparam logic [7:0] ETX_BYTE   = 8'h03;
	localparam logic [7:0] DIGIT_LO   = 8'h30;
	localparam logic [7:0] DIGIT_HI   = 8'h39;
	localparam int unsigned FIELD_W   = 24;
	localparam logic [1:0] LAST_CHAR  = 2'h2;
	localparam logic [1:0] MAX_FIELDS = 2'h3;
	localparam int unsigned WORD_W    = 2 * FIELD_W + 1;
	localparam int unsigned FIFO_D    = 8;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scr_rx_t;
	typedef enum logic [1:0] {P_WAIT, P_ID, P_FIELD, P_PUSH} scr_ps_t;

endpackage

// ### core/scr_fifo.sv
// Purpose: command word buffer between frame parser and command port
// Assumes: single clock, asynchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module scr_fifo #(
	parameter int unsigned W = 49,
	parameter int unsigned D = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int unsigned AW = $clog2(D);

	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} scr_fifo_st_t;

	scr_fifo_st_t q, d;
	logic [W-1:0] mem [D];
	logic         full;
	logic         empty;

	assign full      = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
	assign empty     = (q.wp == q.rp);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[q.rp[AW-1:0]];

	always_comb begin
		d = q;
		if (in_valid && !full) begin
			d.wp = q.wp + 1'b1;
		end
		if (out_ready && !empty) begin
			d.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	always_ff @(posedge clk) begin
		if (in_valid && !full) begin
			mem[q.wp[AW-1:0]] <= in_data;
		end
	end

endmodule // scr_fifo

// ### core/scr_rx.sv
// Purpose: serial command frame receiver, line to decoded command words
// Assumes: RXD already synchronous to REF_CLK, idle high
// Notes:   a frame is checked whole before any of its commands is released
`timescale 1ns/1ps

// How it works
// - line rate selectable, 4800 default, five rates
// - one start, eight data, one stop bit
// - frame opens with 02h and closes 03h
// - every command field is three characters
// - up to three commands, released in order
// - command then argument applies the argument
// - argument is three characters before end byte
module scr_rx #(
	parameter int unsigned DIV_1200  = scr_pkg::DIV_1200,
	parameter int unsigned DIV_2400  = scr_pkg::DIV_2400,
	parameter int unsigned DIV_4800  = scr_pkg::DIV_4800,
	parameter int unsigned DIV_9600  = scr_pkg::DIV_9600,
	parameter int unsigned DIV_19200 = scr_pkg::DIV_19200
) (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        RXD,
	input  wire logic [2:0]  BAUD_SEL,
	input  wire logic [7:0]  UNIT_ID,
	output logic             CMD_VALID,
	input  wire logic        CMD_READY,
	output logic [23:0]      CMD_CODE,
	output logic [23:0]      CMD_ARG,
	output logic             CMD_HAS_ARG,
	output logic             FRAME_DONE,
	output logic             FRAME_DROP,
	output logic             BYTE_LOST
);
	localparam int unsigned DW = scr_pkg::DIVW;
	localparam int unsigned WW = scr_pkg::WORD_W;
	localparam int unsigned FW = scr_pkg::FIELD_W;

	typedef struct packed {
		scr_pkg::scr_rx_t       rxs;
		logic [DW-1:0]          div_cnt;
		logic [3:0]             tk;
		logic [2:0]             bitn;
		logic [7:0]             sh;
		logic                   rx_v;
		logic                   rx_ferr;
		logic [7:0]             rx_b;
		scr_pkg::scr_ps_t       ps;
		logic [2:0][FW-1:0]     fld;
		logic [1:0]             nfld;
		logic [1:0]             cc;
		logic                   has_arg;
		logic [1:0]             idx;
		logic                   ov;
		logic [FW-1:0]          ocmd;
		logic [FW-1:0]          oarg;
		logic                   ohas;
		logic                   done;
		logic                   drop;
		logic                   lost;
	} scr_rx_st_t;

	scr_rx_st_t    q, d;
	logic [DW-1:0] div_w;
	logic          tick;
	logic          push;
	logic [WW-1:0] push_word;
	logic          push_ready;
	logic          pop_valid;
	logic          pop_ready;
	logic [WW-1:0] pop_word;

	function automatic logic is_digit(input logic [7:0] c);
		return (c >= scr_pkg::DIGIT_LO) && (c <= scr_pkg::DIGIT_HI);
	endfunction

	// ------------------------------------------------------------------
	// rate select
	// ------------------------------------------------------------------
	always_comb begin
		case (BAUD_SEL)
			scr_pkg::SEL_1200:  div_w = DW'(DIV_1200);
			scr_pkg::SEL_2400:  div_w = DW'(DIV_2400);
			scr_pkg::SEL_9600:  div_w = DW'(DIV_9600);
			scr_pkg::SEL_19200: div_w = DW'(DIV_19200);
			default:            div_w = DW'(DIV_4800);
		endcase
	end

	assign tick      = (q.div_cnt >= div_w - 1'b1);
	assign pop_ready = !q.ov || CMD_READY;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		d         = q;
		d.rx_v    = 1'b0;
		d.rx_ferr = 1'b0;
		d.done    = 1'b0;
		d.drop    = 1'b0;
		d.lost    = 1'b0;
		push      = 1'b0;
		push_word = '0;

		// oversampling divider
		d.div_cnt = tick ? '0 : q.div_cnt + 1'b1;

		// character deserialiser, lsb first
		if (tick) begin
			case (q.rxs)
				scr_pkg::RX_IDLE: begin
					if (!RXD) begin
						d.rxs = scr_pkg::RX_START;
						d.tk  = '0;
					end
				end
				scr_pkg::RX_START: begin
					if (q.tk == scr_pkg::OVS_MID) begin
						d.tk   = '0;
						d.bitn = '0;
						d.rxs  = RXD ? scr_pkg::RX_IDLE : scr_pkg::RX_DATA;
					end else begin
						d.tk = q.tk + 1'b1;
					end
				end
				scr_pkg::RX_DATA: begin
					d.tk = q.tk + 1'b1;
					if (q.tk == scr_pkg::OVS_LAST) begin
						d.sh = {RXD, q.sh[7:1]};
						if (q.bitn == scr_pkg::LAST_BIT) begin
							d.rxs = scr_pkg::RX_STOP;
						end else begin
							d.bitn = q.bitn + 1'b1;
						end
					end
				end
				scr_pkg::RX_STOP: begin
					d.tk = q.tk + 1'b1;
					if (q.tk == scr_pkg::OVS_LAST) begin
						d.rxs     = scr_pkg::RX_IDLE;
						d.rx_v    = RXD;
						d.rx_ferr = !RXD;
						d.rx_b    = q.sh;
					end
				end
				default: d.rxs = scr_pkg::RX_IDLE;
			endcase
		end

		// frame parser
		if (q.ps == scr_pkg::P_PUSH) begin
			d.lost = q.rx_v || q.rx_ferr;
			push   = 1'b1;
			if (q.has_arg) begin
				push_word = {1'b1, q.fld[0], q.fld[1]};
			end else begin
				push_word = {1'b0, q.fld[q.idx], {FW{1'b0}}};
			end
			if (push_ready) begin
				d.idx = q.idx + 1'b1;
				if (q.has_arg || (q.idx + 1'b1 == q.nfld)) begin
					d.ps   = scr_pkg::P_WAIT;
					d.done = 1'b1;
				end
			end
		end else if (q.rx_ferr) begin
			d.drop = (q.ps != scr_pkg::P_WAIT);
			d.ps   = scr_pkg::P_WAIT;
		end else if (q.rx_v && q.rx_b == scr_pkg::STX_BYTE) begin
			d.drop = (q.ps != scr_pkg::P_WAIT);
			d.ps   = scr_pkg::P_ID;
		end else if (q.rx_v) begin
			case (q.ps)
				scr_pkg::P_WAIT: d.ps = scr_pkg::P_WAIT;
				scr_pkg::P_ID: begin
					if (q.rx_b == UNIT_ID) begin
						d.ps      = scr_pkg::P_FIELD;
						d.nfld    = '0;
						d.cc      = '0;
						d.has_arg = 1'b0;
						d.idx     = '0;
					end else begin
						d.ps   = scr_pkg::P_WAIT;
						d.drop = 1'b1;
					end
				end
				scr_pkg::P_FIELD: begin
					if (q.rx_b == scr_pkg::ETX_BYTE) begin
						if (q.cc == '0 && q.nfld != '0) begin
							d.ps  = scr_pkg::P_PUSH;
							d.idx = '0;
						end else begin
							d.ps   = scr_pkg::P_WAIT;
							d.drop = 1'b1;
						end
					end else if (q.cc == '0 && (q.has_arg ||
							q.nfld == scr_pkg::MAX_FIELDS)) begin
						d.ps   = scr_pkg::P_WAIT;
						d.drop = 1'b1;
					end else begin
						d.fld[q.nfld] = {q.fld[q.nfld][15:0], q.rx_b};
						if (q.cc == scr_pkg::LAST_CHAR) begin
							d.cc   = '0;
							d.nfld = q.nfld + 1'b1;
							if (q.nfld == 2'h1 && is_digit(q.fld[1][15:8])) begin
								d.has_arg = 1'b1;
							end
						end else begin
							d.cc = q.cc + 1'b1;
						end
					end
				end
				default: d.ps = scr_pkg::P_WAIT;
			endcase
		end

		// registered command port
		if (pop_valid && pop_ready) begin
			d.ov   = 1'b1;
			d.ohas = pop_word[WW-1];
			d.ocmd = pop_word[2*FW-1:FW];
			d.oarg = pop_word[FW-1:0];
		end else if (CMD_READY) begin
			d.ov = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			q     <= '0;
			q.rxs <= scr_pkg::RX_IDLE;
			q.ps  <= scr_pkg::P_WAIT;
		end else begin
			q <= d;
		end
	end

	scr_fifo #(
		.W (WW),
		.D (scr_pkg::FIFO_D)
	) u_fifo (
		.clk       (REF_CLK),
		.rst       (RST),
		.in_valid  (push),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_word)
	);

	assign CMD_VALID   = q.ov;
	assign CMD_CODE    = q.ocmd;
	assign CMD_ARG     = q.oarg;
	assign CMD_HAS_ARG = q.ohas;
	assign FRAME_DONE  = q.done;
	assign FRAME_DROP  = q.drop;
	assign BYTE_LOST   = q.lost;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	sequence s_byte_in;
		q.rx_v && q.rx_b != scr_pkg::STX_BYTE && q.ps != scr_pkg::P_PUSH;
	endsequence

	sequence s_end_ok;
		q.ps == scr_pkg::P_FIELD && q.cc == '0 && q.nfld != '0 &&
		q.rx_b == scr_pkg::ETX_BYTE;
	endsequence

	divider_range_a: assert property ($stable(BAUD_SEL) |->
		q.div_cnt < div_w)
		else $error("oversampling divider out of range");
	stop_bit_a: assert property (q.rx_v |-> $past(RXD) &&
		$past(q.rxs == scr_pkg::RX_STOP))
		else $error("byte accepted without high stop bit");
	stx_restart_a: assert property (q.rx_v && !q.rx_ferr &&
		q.rx_b == scr_pkg::STX_BYTE && q.ps != scr_pkg::P_PUSH
		|=> q.ps == scr_pkg::P_ID)
		else $error("start byte did not restart frame");
	etx_push_a: assert property (s_byte_in and s_end_ok
		|=> push && push_word[2*FW-1:FW] == q.fld[0])
		else $error("end byte did not release commands");
	three_char_a: assert property (s_byte_in and (q.ps == scr_pkg::P_FIELD &&
		q.cc == scr_pkg::LAST_CHAR && q.rx_b != scr_pkg::ETX_BYTE)
		|=> q.cc == '0 && q.nfld == $past(q.nfld) + 2'h1)
		else $error("field not closed after three characters");
	fourth_cmd_a: assert property (s_byte_in and (q.ps == scr_pkg::P_FIELD &&
		q.cc == '0 && q.nfld == scr_pkg::MAX_FIELDS &&
		q.rx_b != scr_pkg::ETX_BYTE) |=> FRAME_DROP && q.ps == scr_pkg::P_WAIT)
		else $error("fourth command field not rejected");
	arg_word_a: assert property (push && q.has_arg |-> push_word[WW-1] &&
		push_word[FW-1:0] == q.fld[1])
		else $error("argument not attached to command");
	arg_end_a: assert property (s_byte_in and (q.ps == scr_pkg::P_FIELD &&
		q.has_arg && q.cc == '0 && q.rx_b != scr_pkg::ETX_BYTE)
		|=> FRAME_DROP)
		else $error("byte after argument not rejected");
	id_reject_a: assert property (s_byte_in and (q.ps == scr_pkg::P_ID &&
		q.rx_b != UNIT_ID) |=> FRAME_DROP && q.ps == scr_pkg::P_WAIT)
		else $error("foreign unit frame not dropped");
	cmd_hold_a: assert property (CMD_VALID && !CMD_READY |=> CMD_VALID &&
		$stable(CMD_CODE) && $stable(CMD_ARG))
		else $error("command word changed while stalled");

endmodule // scr_rx

// ### verification/scr_host.sv
// Purpose: host computer side of the serial line, sends 8N1 frames
// Assumes: bit time given in REF_CLK cycles, same rate as the receiver
// Notes:   line idles high between characters and frames
`timescale 1ns/1ps
module scr_host (
	input  wire logic ref_clk,
	output logic      rxd
);
	initial rxd = 1'b1;

	// start, eight data lsb first, stop; bad_stop sends a low stop bit
	task automatic send_byte(input logic [7:0] b, input int bc,
		input logic bad_stop);
		logic [9:0] f;
		f = {~bad_stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			#1 rxd = f[i];
			repeat (bc - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		#1 rxd = 1'b1;
	endtask

	// open byte, id, nc characters taken from the top of f, end byte
	task automatic send_frame(input logic [7:0] id, input logic [95:0] f,
		input int nc, input int bc);
		send_byte(scr_pkg::STX_BYTE, bc, 1'b0);
		send_byte(id, bc, 1'b0);
		for (int i = 0; i < nc; i++) begin
			send_byte(f[95 - 8 * i -: 8], bc, 1'b0);
		end
		send_byte(scr_pkg::ETX_BYTE, bc, 1'b0);
	endtask
endmodule // scr_host

// ### verification/serial_command_frame_receiver_tb.sv
// Purpose: self-checking bench for the serial command frame receiver
// Assumes: short divider values so a bit lasts 32 to 96 cycles
// Notes:   collector pops words; counts drop, done and lost pulses
`timescale 1ns/1ps
module serial_command_frame_receiver_tb;
	localparam int        D4    = 4;
	localparam int        D1    = 6;
	localparam int        D2    = 5;
	localparam int        D9    = 3;
	localparam int        D19   = 2;
	localparam int        LIMIT = 100000;
	localparam logic [7:0] MY_ID = 8'h31;
	typedef struct {
		logic [2:0]  sel;
		logic [7:0]  id;
		logic [95:0] f;
		int          nc;
		int          nw;
		logic        ha;
	} scr_row_t;

	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        rxd;
	logic [2:0]  baud_sel = 3'h0;
	logic [7:0]  unit_id = MY_ID;
	logic        cmd_ready = 1'b1;
	logic        cmd_valid, cmd_has_arg, frame_done, frame_drop, byte_lost;
	logic [23:0] cmd_code, cmd_arg;
	logic [48:0] got[$];
	int          fail_count = 0, cmp_count = 0, cyc = 0;
	int          n_drop = 0, n_done = 0, n_lost = 0, d, e, lo;
	scr_row_t    rows[6];
	scr_row_t    r;
	logic [95:0] ff[4];

	always #5 ref_clk = ~ref_clk;

	scr_host host (.ref_clk(ref_clk), .rxd(rxd));

	scr_rx #(.DIV_1200(D1), .DIV_2400(D2), .DIV_4800(D4), .DIV_9600(D9),
		.DIV_19200(D19)) DUT (
		.REF_CLK(ref_clk), .RST(rst), .RXD(rxd), .BAUD_SEL(baud_sel),
		.UNIT_ID(unit_id), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.CMD_CODE(cmd_code), .CMD_ARG(cmd_arg), .CMD_HAS_ARG(cmd_has_arg),
		.FRAME_DONE(frame_done), .FRAME_DROP(frame_drop),
		.BYTE_LOST(byte_lost));

	always @(posedge ref_clk) begin
		cyc++;
		if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
			got.push_back({cmd_has_arg, cmd_code, cmd_arg});
		if (frame_drop === 1'b1) n_drop++;
		if (frame_done === 1'b1) n_done++;
		if (byte_lost === 1'b1) n_lost++;
		if (cyc == LIMIT) begin
			fail_count++;
			complete_run();
		end
	end

	function automatic int bitc(input logic [2:0] s);
		case (s)
			3'h1: return 16 * D1;
			3'h2: return 16 * D2;
			3'h3: return 16 * D9;
			3'h4: return 16 * D19;
			default: return 16 * D4;
		endcase
	endfunction

	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	task automatic settle();
		repeat (40) @(posedge ref_clk);
		#1;
	endtask

	task automatic check_words(input scr_row_t w);
		logic [48:0] x;
		for (int i = 0; i < w.nw; i++) begin
			if (w.ha) x = {1'b1, w.f[95:48]};
			else x = {1'b0, w.f[95 - 24 * i -: 24], 24'h0000};
			chk(got.size() > 0 && got[0] === x, "command word");
			if (got.size() > 0) void'(got.pop_front());
		end
	endtask

	task automatic bad(input logic [95:0] f, input int nc);
		d = n_drop;
		host.send_frame(MY_ID, f, nc, bitc(3'h0));
		settle();
		chk(n_drop == d + 1, "bad frame not dropped");
		chk(got.size() == 0, "word from bad frame");
	endtask

	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		rows[0] = '{3'h0, MY_ID, {"ABL128", 48'h0}, 6, 1, 1'b1};
		rows[1] = '{3'h1, MY_ID, {"AJYAOFAON", 24'h0}, 9, 3, 1'b0};
		rows[2] = '{3'h2, MY_ID, {"AOF", 72'h0}, 3, 1, 1'b0};
		rows[3] = '{3'h3, 8'h35, {"AON", 72'h0}, 3, 0, 1'b0};
		rows[4] = '{3'h4, MY_ID, {"B00B01", 48'h0}, 6, 2, 1'b0};
		rows[5] = '{3'h5, MY_ID, {"AJN", 72'h0}, 3, 1, 1'b0};
		ff[0] = {"AJYAOFAON", 24'h0};
		ff[1] = {"AONAJNAJY", 24'h0};
		ff[2] = {"B00B01B02", 24'h0};
		ff[3] = {"B03B04B06", 24'h0};
		repeat (2) @(posedge ref_clk);
		#1;
		chk({cmd_valid, frame_done, frame_drop, byte_lost} === 4'h0, "reset");
		repeat (2) @(posedge ref_clk);
		#1 rst = 1'b0;
		@(posedge ref_clk);
		#1;
		chk({cmd_valid, cmd_code, cmd_arg} === 49'h0, "after reset");
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			baud_sel = rows[k].sel;
			d = n_drop;
			e = n_done;
			host.send_frame(rows[k].id, rows[k].f, rows[k].nc,
				bitc(rows[k].sel));
			settle();
			check_words(rows[k]);
			chk(got.size() == 0, "extra word");
			chk(n_drop - d == (rows[k].nw == 0), "drop count");
			chk(n_done - e == (rows[k].nw != 0), "done count");
			$display("test row %0d done", k);
		end
		baud_sel = 3'h0;
		bad({"AB", 80'h0}, 2);
		bad({"AJYAOFAONAJN"}, 12);
		bad({"ABL128AOF", 24'h0}, 9);
		d = n_drop;
		host.send_byte(scr_pkg::STX_BYTE, bitc(3'h0), 1'b0);
		host.send_byte(MY_ID, bitc(3'h0), 1'b0);
		host.send_byte(8'h41, bitc(3'h0), 1'b1);
		settle();
		chk(n_drop == d + 1, "framing error not dropped");
		r = '{3'h0, MY_ID, {"AOF", 72'h0}, 3, 1, 1'b0};
		host.send_frame(MY_ID, r.f, 3, bitc(3'h0));
		settle();
		check_words(r);
		$display("test bad frames done");
		cmd_ready = 1'b0;
		for (int k = 0; k < 4; k++)
			host.send_frame(MY_ID, ff[k], 9, bitc(3'h0));
		settle();
		chk(cmd_valid === 1'b1 && got.size() == 0, "word not held");
		lo = n_lost;
		host.send_byte(8'h41, bitc(3'h0), 1'b0);
		settle();
		chk(n_lost == lo + 1, "byte during stall not flagged");
		cmd_ready = 1'b1;
		settle();
		for (int k = 0; k < 4; k++) begin
			r = '{3'h0, MY_ID, ff[k], 9, 3, 1'b0};
			check_words(r);
		end
		chk(got.size() == 0 && cmd_valid === 1'b0, "fifo not empty");
		$display("test fifo done");
		// an open frame cut by a new start byte is dropped, the new one kept
		baud_sel = 3'h4;
		d = n_drop;
		host.send_byte(scr_pkg::STX_BYTE, bitc(3'h4), 1'b0);
		host.send_byte(MY_ID, bitc(3'h4), 1'b0);
		host.send_byte(8'h41, bitc(3'h4), 1'b0);
		r = '{3'h4, MY_ID, {"AON", 72'h0}, 3, 1, 1'b0};
		host.send_frame(MY_ID, r.f, 3, bitc(3'h4));
		settle();
		chk(n_drop == d + 1, "open frame not dropped");
		check_words(r);
		// the unit id input decides which frames are taken
		unit_id = 8'h35;
		host.send_frame(8'h35, r.f, 3, bitc(3'h4));
		settle();
		check_words(r);
		chk(got.size() == 0, "extra word after id change");
		$display("test restart and id done");
		complete_run();
	end
endmodule // serial_command_frame_receiver_tb
